// *** ivpu_pkg.sv ***
// Constants for the interrupt vector and priority unit.
// Assumes a 128-word vector table placed by a vector base held outside.
package ivpu_pkg;

	// Hardware sources, one per priority, index = priority - 1
	localparam int IVPU_NSRC = 16;
	localparam int IVPU_NMASK = 14;
	localparam int IVPU_LOC_W = 7;
	localparam int IVPU_PRI_W = 5;
	localparam int IVPU_NUM_W = 5;
	localparam int IVPU_VBASE_W = 9;

	// Vector-relative locations, in priority order
	localparam logic [6:0] IVPU_LOC_RESET = 7'h00;
	localparam logic [6:0] IVPU_LOC_NMI = 7'h04;
	localparam logic [6:0] IVPU_LOC_EXT_USER_IRQ0 = 7'h40;
	localparam logic [6:0] IVPU_LOC_EXT_USER_IRQ1 = 7'h44;
	localparam logic [6:0] IVPU_LOC_EXT_USER_IRQ2 = 7'h48;
	localparam logic [6:0] IVPU_LOC_TIMER = 7'h4C;
	localparam logic [6:0] IVPU_LOC_S0RX = 7'h50;
	localparam logic [6:0] IVPU_LOC_S0TX = 7'h54;
	localparam logic [6:0] IVPU_LOC_S2RX = 7'h58;
	localparam logic [6:0] IVPU_LOC_S2TX = 7'h5C;
	localparam logic [6:0] IVPU_LOC_EXT_USER_IRQ3 = 7'h60;
	localparam logic [6:0] IVPU_LOC_HOST = 7'h64;
	localparam logic [6:0] IVPU_LOC_S1RX = 7'h68;
	localparam logic [6:0] IVPU_LOC_S1TX = 7'h6C;
	localparam logic [6:0] IVPU_LOC_DMA4 = 7'h70;
	localparam logic [6:0] IVPU_LOC_DMA5 = 7'h74;
	localparam logic [6:0] IVPU_LOC_RSV_LO = 7'h78;

	// Software trap numbers served through the table gap 08..3C
	localparam logic [4:0] IVPU_SOFT_MIN = 5'h11;
	localparam logic [4:0] IVPU_SOFT_MAX = 5'h1E;
	localparam logic [6:0] IVPU_LOC_SOFT_LO = 7'h08;

	// Reset values
	localparam logic [15:0] IVPU_FLAG_RST = 16'h0000;
	localparam logic [4:0] IVPU_PRI_SOFT = 5'h00;

	localparam logic [6:0] IVPU_LOC_TAB [IVPU_NSRC] = '{
		IVPU_LOC_RESET, IVPU_LOC_NMI, IVPU_LOC_EXT_USER_IRQ0, IVPU_LOC_EXT_USER_IRQ1,
		IVPU_LOC_EXT_USER_IRQ2, IVPU_LOC_TIMER, IVPU_LOC_S0RX, IVPU_LOC_S0TX,
		IVPU_LOC_S2RX, IVPU_LOC_S2TX, IVPU_LOC_EXT_USER_IRQ3, IVPU_LOC_HOST,
		IVPU_LOC_S1RX, IVPU_LOC_S1TX, IVPU_LOC_DMA4, IVPU_LOC_DMA5};

	typedef enum logic {IVPU_IDLE, IVPU_SHOW} ivpu_state_e;

endpackage : ivpu_pkg

// *** ivpu_top.sv ***
// Interrupt vector and priority unit: flags, fixed arbitration, vector out.
// Assumes one-cycle event pulses from sources and a core that acknowledges.
`timescale 1ns/1ps
module ivpu_top
#(
	parameter int VBASE_W = ivpu_pkg::IVPU_VBASE_W
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	// Reset and nonmaskable sources
	input wire logic reset_input,
	input wire logic soft_reset_trap,
	input wire logic nmi_irq,
	// Maskable sources
	input wire logic ext_user_irq0,
	input wire logic ext_user_irq1,
	input wire logic ext_user_irq2,
	input wire logic ext_user_irq3,
	input wire logic timer_irq,
	input wire logic serial0_rx_irq,
	input wire logic serial0_tx_irq,
	input wire logic serial1_rx_irq,
	input wire logic serial1_tx_irq,
	input wire logic serial2_rx_irq,
	input wire logic serial2_tx_irq,
	input wire logic host_port_irq,
	input wire logic dma_ch4_irq,
	input wire logic dma_ch5_irq,
	// Core side control
	input wire logic [ivpu_pkg::IVPU_NMASK-1:0] irq_mask_reg,
	input wire logic irq_global_dis,
	input wire logic [VBASE_W-1:0] vector_base,
	input wire logic soft_req,
	input wire logic [ivpu_pkg::IVPU_NUM_W-1:0] soft_num,
	input wire logic irq_ack,
	// Core side results
	output logic irq_req_q,
	output logic [ivpu_pkg::IVPU_LOC_W-1:0] irq_loc_q,
	output logic [VBASE_W+ivpu_pkg::IVPU_LOC_W-1:0] irq_addr_q,
	output logic [ivpu_pkg::IVPU_PRI_W-1:0] irq_pri_q,
	output logic [ivpu_pkg::IVPU_NSRC-1:0] irq_flag_reg_q,
	output logic soft_pend_q
);
	import ivpu_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Source collection and gating

	logic [IVPU_NSRC-1:0] src_evt;
	logic [IVPU_NSRC-1:0] enabled;
	logic [IVPU_NSRC-1:0] below_win;
	logic [IVPU_NSRC-1:0] clr_mask;
	logic [IVPU_NSRC-1:0] flag_d;
	logic [3:0] win_idx;
	logic win_any;
	logic urgent;
	logic soft_ok;
	logic soft_take;
	logic ack_take;
	logic pick_hw;
	logic pick_soft;
	logic [IVPU_LOC_W-1:0] pick_loc;
	logic [IVPU_PRI_W-1:0] pick_pri;
	logic sel_hw_q;
	logic [3:0] sel_idx_q;
	logic [IVPU_NUM_W-1:0] soft_num_q;
	ivpu_state_e state_q;
	ivpu_state_e state_d;

	// reset from pin or software trap
	assign src_evt = {dma_ch5_irq, dma_ch4_irq, serial1_tx_irq,
		serial1_rx_irq, host_port_irq, ext_user_irq3, serial2_tx_irq,
		serial2_rx_irq, serial0_tx_irq, serial0_rx_irq, timer_irq,
		ext_user_irq2, ext_user_irq1, ext_user_irq0, nmi_irq,
		reset_input | soft_reset_trap};

	// Reset and nonmaskable bypass both mask and global disable
	assign enabled = irq_flag_reg_q &
		{irq_mask_reg & {IVPU_NMASK{~irq_global_dis}}, 2'b11};

	always_comb begin
		win_idx = 4'h0;
		win_any = 1'b0;
		for (int i = IVPU_NSRC - 1; i >= 0; i--) begin
			if (enabled[i]) begin
				win_idx = 4'(i);
				win_any = 1'b1;
			end
		end
	end

	assign urgent = enabled[0] | enabled[1];

	////////////////////////////////////////////////////////////////////////
	// Selection and handshake

	// only the gap numbers are honoured
	assign soft_ok = soft_num >= IVPU_SOFT_MIN && soft_num <= IVPU_SOFT_MAX;
	assign soft_take = soft_req & soft_ok & ~soft_pend_q;
	assign ack_take = (state_q == IVPU_SHOW) & irq_ack;

	// Traps run in program order, so they beat maskable sources only
	assign pick_hw = urgent | (win_any & ~soft_pend_q);
	assign pick_soft = ~urgent & soft_pend_q;

	assign pick_loc = pick_hw ? IVPU_LOC_TAB[win_idx] :
		IVPU_LOC_SOFT_LO +
		IVPU_LOC_W'({soft_num_q - IVPU_SOFT_MIN, 2'b00});
	assign pick_pri = pick_hw ? IVPU_PRI_W'(win_idx + 5'h01) : IVPU_PRI_SOFT;

	assign clr_mask = (ack_take & sel_hw_q) ?
		IVPU_NSRC'(16'h0001 << sel_idx_q) : '0;
	// Set wins over a clear in the same cycle
	assign flag_d = (irq_flag_reg_q & ~clr_mask) | src_evt;

	always_comb begin
		state_d = state_q;
		case (state_q)
			IVPU_IDLE: begin
				if (pick_hw | pick_soft) begin
					state_d = IVPU_SHOW;
				end
			end
			IVPU_SHOW: begin
				if (irq_ack) begin
					state_d = IVPU_IDLE;
				end
			end
			default: state_d = IVPU_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_flag_reg_q <= IVPU_FLAG_RST;
			state_q <= IVPU_IDLE;
			irq_req_q <= 1'b0;
			irq_loc_q <= IVPU_LOC_RESET;
			irq_addr_q <= '0;
			irq_pri_q <= IVPU_PRI_SOFT;
			sel_hw_q <= 1'b0;
			sel_idx_q <= 4'h0;
			soft_pend_q <= 1'b0;
			soft_num_q <= 5'h00;
		end else if (clk_en) begin
			irq_flag_reg_q <= flag_d;
			state_q <= state_d;
			irq_req_q <= state_d == IVPU_SHOW;
			if (soft_take) begin
				soft_pend_q <= 1'b1;
				soft_num_q <= soft_num;
			end else if (ack_take & ~sel_hw_q) begin
				soft_pend_q <= 1'b0;
			end
			if (state_q == IVPU_IDLE && (pick_hw | pick_soft)) begin
				irq_loc_q <= pick_loc;
				irq_addr_q <= {vector_base, pick_loc};
				irq_pri_q <= pick_pri;
				sel_hw_q <= pick_hw;
				sel_idx_q <= win_idx;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic [IVPU_NSRC-1:0] prio_mask;
	assign prio_mask = IVPU_NSRC'((17'h00001 << irq_pri_q) - 17'h00001);
	// Mask of priorities above the one now presented
	assign below_win = prio_mask >> 1;

	property p_reset_vec;
		@(posedge mclk) disable iff (!nrst)
		irq_req_q && irq_pri_q == 5'h01 |-> irq_loc_q == 7'h00;
	endproperty
	a_reset_vec: assert property (p_reset_vec)
		else $error("reset vector wrong");

	property p_nmi_vec;
		@(posedge mclk) disable iff (!nrst)
		irq_req_q && irq_pri_q == 5'h02 |-> irq_loc_q == 7'h04;
	endproperty
	a_nmi_vec: assert property (p_nmi_vec)
		else $error("nonmaskable vector wrong");

	sequence s_new_hw;
		clk_en && state_q == IVPU_IDLE ##1 irq_req_q && irq_pri_q != 5'h00;
	endsequence
	property p_prio_order;
		@(posedge mclk) disable iff (!nrst)
		s_new_hw |-> ($past(enabled) & below_win) == '0 &&
			(irq_addr_q == {vector_base, irq_loc_q} ||
			!$stable(vector_base));
	endproperty
	a_prio_order: assert property (p_prio_order)
		else $error("lower priority served first");

	property p_user_vec;
		@(posedge mclk) disable iff (!nrst)
		irq_req_q && irq_pri_q >= 5'h03 && irq_pri_q <= 5'h05 |->
			irq_loc_q == 7'(7'h40 + 7'({irq_pri_q - 5'h03, 2'b00}));
	endproperty
	a_user_vec: assert property (p_user_vec)
		else $error("user interrupt vector wrong");

	property p_user3_vec;
		@(posedge mclk) disable iff (!nrst)
		irq_req_q && irq_pri_q == 5'h0B |-> irq_loc_q == 7'h60;
	endproperty
	a_user3_vec: assert property (p_user3_vec)
		else $error("user interrupt 3 vector wrong");

	property p_rx_vec;
		@(posedge mclk) disable iff (!nrst)
		irq_req_q |-> (irq_pri_q != 5'h07 || irq_loc_q == 7'h50) &&
			(irq_pri_q != 5'h09 || irq_loc_q == 7'h58) &&
			(irq_pri_q != 5'h0D || irq_loc_q == 7'h68);
	endproperty
	a_rx_vec: assert property (p_rx_vec)
		else $error("serial receive vector wrong");

	property p_tx_vec;
		@(posedge mclk) disable iff (!nrst)
		irq_req_q |-> (irq_pri_q != 5'h08 || irq_loc_q == 7'h54) &&
			(irq_pri_q != 5'h0A || irq_loc_q == 7'h5C) &&
			(irq_pri_q != 5'h0E || irq_loc_q == 7'h6C);
	endproperty
	a_tx_vec: assert property (p_tx_vec)
		else $error("serial transmit vector wrong");

	property p_dma_vec;
		@(posedge mclk) disable iff (!nrst)
		irq_req_q |-> irq_loc_q < IVPU_LOC_RSV_LO &&
			(irq_pri_q != 5'h0F || irq_loc_q == 7'h70) &&
			(irq_pri_q != 5'h10 || irq_loc_q == 7'h74);
	endproperty
	a_dma_vec: assert property (p_dma_vec)
		else $error("dma or reserved vector wrong");

	property p_soft_vec;
		@(posedge mclk) disable iff (!nrst)
		clk_en && soft_take && !win_any && state_q == IVPU_IDLE
			##1 clk_en && !urgent |=> irq_req_q && irq_pri_q == 5'h00 &&
			irq_loc_q >= 7'h08 && irq_loc_q <= 7'h3C;
	endproperty
	a_soft_vec: assert property (p_soft_vec)
		else $error("software trap not served");

	property p_flag_set;
		@(posedge mclk) disable iff (!nrst)
		clk_en && src_evt[15] |=> irq_flag_reg_q[15];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("flag lost");

endmodule : ivpu_top

// *** ivpu_core_model.sv ***
// Core model: acknowledges each presented vector and logs what it took.
// Assumes the unit holds its vector until the acknowledging edge.
`timescale 1ns/1ps
module ivpu_core_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Unit side
	input wire logic irq_req_q,
	input wire logic [6:0] irq_loc_q,
	input wire logic [15:0] irq_addr_q,
	input wire logic [4:0] irq_pri_q,
	// Bench control: stall makes the core slow to answer
	input wire logic stall,
	output logic irq_ack
);
	logic [27:0] logq[$];
	// Ack is one pulse; the vector is logged at the edge that takes it
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_ack <= 1'b0;
		end else if (irq_ack) begin
			logq.push_back({irq_pri_q, irq_loc_q, irq_addr_q});
			irq_ack <= 1'b0;
		end else begin
			irq_ack <= irq_req_q && !stall;
		end
	end
endmodule : ivpu_core_model

// *** test_interrupt_vector_priority_unit.sv ***
// Bench for the vector and priority unit: table, order, traps, masking.
// Assumes the core model acknowledges every presented vector.
`timescale 1ns/1ps
module test_interrupt_vector_priority_unit;
	import ivpu_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] src = 16'h0000;
	logic srt = 1'b0;
	logic soft_req = 1'b0;
	logic stall = 1'b0;
	logic gdis = 1'b0;
	logic cen = 1'b1;
	logic [4:0] soft_num = 5'h00;
	logic [13:0] mask = 14'h3FFF;
	logic [8:0] vbase = 9'h1A5;
	logic req, ack, pend;
	logic [6:0] loc;
	logic [15:0] addr, flag;
	logic [4:0] pri;
	int miscompares = 0;
	int compares = 0;
	logic [6:0] loc_tab [16] = '{7'h00, 7'h04, 7'h40, 7'h44, 7'h48, 7'h4C,
		7'h50, 7'h54, 7'h58, 7'h5C, 7'h60, 7'h64, 7'h68, 7'h6C, 7'h70, 7'h74};
	always #5 mclk = ~mclk;
	ivpu_top ivpu_top_i (.mclk(mclk), .nrst(nrst), .clk_en(cen),
		.reset_input(src[0]), .soft_reset_trap(srt), .nmi_irq(src[1]),
		.ext_user_irq0(src[2]), .ext_user_irq1(src[3]),
		.ext_user_irq2(src[4]), .timer_irq(src[5]),
		.serial0_rx_irq(src[6]), .serial0_tx_irq(src[7]),
		.serial2_rx_irq(src[8]), .serial2_tx_irq(src[9]),
		.ext_user_irq3(src[10]), .host_port_irq(src[11]),
		.serial1_rx_irq(src[12]), .serial1_tx_irq(src[13]),
		.dma_ch4_irq(src[14]), .dma_ch5_irq(src[15]),
		.irq_mask_reg(mask), .irq_global_dis(gdis), .vector_base(vbase),
		.soft_req(soft_req), .soft_num(soft_num), .irq_ack(ack),
		.irq_req_q(req), .irq_loc_q(loc), .irq_addr_q(addr),
		.irq_pri_q(pri), .irq_flag_reg_q(flag), .soft_pend_q(pend));
	ivpu_core_model ivpu_core_model_i (.mclk(mclk), .nrst(nrst),
		.irq_req_q(req), .irq_loc_q(loc), .irq_addr_q(addr),
		.irq_pri_q(pri), .stall(stall), .irq_ack(ack));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [27:0] seen, input logic [27:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic pulse(input logic [15:0] s);
		@(negedge mclk) src = s;
		@(negedge mclk) src = 16'h0000;
	endtask : pulse
	// Waits bounded; an empty log compares as an impossible value
	task automatic expect_vec(input logic [6:0] l, input logic [4:0] p);
		for (int k = 0; k < 60 && ivpu_core_model_i.logq.size() == 0; k++)
			@(posedge mclk);
		check(ivpu_core_model_i.logq.size() ?
			ivpu_core_model_i.logq.pop_front() : 28'hFFFFFFF,
			{p, l, vbase, l});
		@(negedge mclk);
	endtask : expect_vec
	////////////////////////////////////////////////////////////////////////
	task automatic t_table;
		for (int i = 0; i < 16; i++) begin
			pulse(16'h0001 << i);
			expect_vec(loc_tab[i], 5'(i + 1));
		end
		@(negedge mclk) srt = 1'b1;
		@(negedge mclk) srt = 1'b0;
		expect_vec(7'h00, 5'h01);
	endtask : t_table
	task automatic t_order;
		stall = 1'b1;
		@(negedge mclk) src = 16'hFFFF;
		soft_req = 1'b1;
		soft_num = 5'h11;
		@(negedge mclk) src = 16'h0000;
		soft_req = 1'b0;
		repeat (3) @(negedge mclk);
		check(flag, 16'hFFFF);
		stall = 1'b0;
		expect_vec(7'h00, 5'h01);
		expect_vec(7'h04, 5'h02);
		expect_vec(7'h08, 5'h00);
		for (int i = 2; i < 16; i++)
			expect_vec(loc_tab[i], 5'(i + 1));
	endtask : t_order
	task automatic t_soft;
		for (int n = 17; n <= 30; n++) begin
			@(negedge mclk) soft_req = 1'b1;
			soft_num = 5'(n);
			@(negedge mclk) soft_req = 1'b0;
			expect_vec(7'((n - 15) * 4), 5'h00);
		end
		foreach (loc_tab[j]) if (j == 0 || j == 15) begin
			@(negedge mclk) soft_req = 1'b1;
			soft_num = j ? 5'h1F : 5'h10;
			@(negedge mclk) soft_req = 1'b0;
			repeat (4) @(negedge mclk);
			check({req, pend}, 2'b00);
		end
	endtask : t_soft
	task automatic t_mask;
		mask = 14'h3FF7;
		pulse(16'h0020);
		repeat (4) @(negedge mclk);
		check({req, flag[5]}, 2'b01);
		mask = 14'h3FFF;
		expect_vec(7'h4C, 5'h06);
		gdis = 1'b1;
		pulse(16'h8000);
		repeat (4) @(negedge mclk);
		check({req, flag[15]}, 2'b01);
		gdis = 1'b0;
		expect_vec(7'h74, 5'h10);
		@(negedge mclk) cen = 1'b0;
		pulse(16'h0020);
		repeat (2) @(negedge mclk);
		check({req, flag[5]}, 2'b00);
		cen = 1'b1;
	endtask : t_mask
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (6) @(negedge mclk);
		nrst = 1'b1;
		t_table();
		t_order();
		t_soft();
		t_mask();
		give_verdict();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end
endmodule : test_interrupt_vector_priority_unit
